//--- src/crt_raster_defs.vh
`ifndef CRT_RASTER_DEFS_VH
`define CRT_RASTER_DEFS_VH

// Register byte offsets
`define CTRL_OFS        4'h0
`define FMT_A_OFS       4'h4
`define FMT_B_OFS       4'h8
`define STATUS_OFS      4'hC

// Control register fields
`define CTRL_EN_BIT     0
`define CTRL_IRQEN_BIT  1
`define CTRL_SPACED_BIT 2
`define CTRL_LMODE_BIT  3
`define CTRL_RST_BIT    4
`define CTRL_RST_VAL    4'h0

// Format A fields: characters-1, rows-1, vertical retrace rows-1, lines-1, underline
`define CHARS_LSB       0
`define ROWS_LSB        8
`define VRET_LSB        16
`define LINES_LSB       20
`define UL_LSB          24
`define FMT_A_RST_VAL   28'h999_184F

// Format B fields: horizontal retrace clocks-1, burst length-1, burst space
`define HRET_LSB        0
`define BURST_LSB       8
`define SPACE_LSB       16
`define FMT_B_RST_VAL   22'h07_030F

// Status register bits
`define ST_IRQ_BIT      0
`define ST_UNDERRUN_BIT 1
`define ST_VRET_BIT     2
`define ST_FULL_BIT     3

// Row buffer geometry
`define ROW_LEN         8'h50
`define MAX_COL         7'h4F

// Blink divider: frame counter bit giving refresh/32
`define BLINK_BIT       4

// Character attribute code for a horizontal line symbol
`define ATTR_HLINE      4'h8

`endif

//--- src/crt_raster_row_buffer.v
// Notes on behaviour
// R1: Before each frame, DMA fills one row buffer with the first row.
// R2: Display one buffer while DMA fills the other; swap after each row.
// R3: 1 to 80 characters per row, 1 to 64 rows per frame.
// R4: Spaced mode shows even-indexed rows, blanks others, no DMA for them.
// R5: Line count steady over a sweep, advances in horizontal retrace.
// R6: 1 to 16 lines per row; 4-bit line count addresses character ROM.
// R7: Mode 0 outputs line number; mode 1 outputs line minus one, wrapping.
// R8: Underline line 0 to 15, by line number, not counter mode.
// R9: Underline above 7 blanks top and bottom lines; beyond rows means none.
// R10: Count characters, advance line, count horizontal retrace 2 to 32; hret_m1 of 0 gives a 1-clock retrace here.
// R11: After last line of a row, advance row counter, restart at line 0.
// R12: After last row, count vertical retrace of 1 to 4 row times.
// R13: Video suppress active during all horizontal and vertical retrace.
// R14: Bursts of 1 to 8 requests, spaced 0 to 55 clocks apart.
// R15: First frame request one row time before vertical retrace ends.
// R16: Buffer full mid-burst ends burst, clears counter, no more requests.
// R17: Row fill starts at first clock of preceding row, after burst space.
// R18: Row buffer not full in time sets sticky underrun status flag.
// R19: With interrupt enabled, interrupt at start of last display row.
// R20: Status read or reset command drops interrupt; software resets at start.
// R21: MSB 0 is display character, low 7 bits go to character code.
// R22: Blink via video suppress at refresh/32; highlight drives highlight out.
// R23: All counters, swaps and DMA timing run on the character clock.
//
// The register addresses and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
`include "crt_raster_defs.vh"

module crt_raster_row_buffer (
    input  wire        mclk,
    input  wire        reset_n,
    input  wire [3:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [31:0] writedata,
    output wire [31:0] readdata,
    output wire        waitrequest,
    output wire        dma_request_out,
    input  wire        dma_ack,
    input  wire [7:0]  dma_data,
    output wire        irq_out,
    output wire [6:0]  character_code_out,
    output wire [3:0]  line_count_out,
    output wire        video_suppress_out,
    output wire        light_enable_out,
    output wire        highlight_out,
    output wire        horizontal_retrace_out,
    output wire        vertical_retrace_out
);

    localparam DMA_IDLE  = 3'b001;
    localparam DMA_SPACE = 3'b010;
    localparam DMA_BURST = 3'b100;

    reg         served_ff;
    reg  [31:0] readdata_ff;
    reg  [3:0]  ctrl_ff;
    reg  [27:0] fmt_a_ff;
    reg  [21:0] fmt_b_ff;
    reg         irq_ff;
    reg         underrun_ff;

    reg  [6:0]  col_ff;
    reg         hret_ff;
    reg  [4:0]  hcnt_ff;
    reg  [3:0]  line_ff;
    reg  [5:0]  row_ff;
    reg         vret_ff;
    reg  [1:0]  vcnt_ff;
    reg  [4:0]  frame_ff;

    reg  [7:0]  row_mem [0:159];
    reg         disp_sel_ff;
    reg         row_ok_ff;
    reg         fill_req_ff;
    reg         fill_full_ff;
    reg  [6:0]  fill_ptr_ff;
    reg  [2:0]  burst_ff;
    reg  [5:0]  space_ff;
    reg  [2:0]  dma_state_ff;

    reg  [6:0]  code_ff;
    reg  [3:0]  lc_ff;
    reg         vsp_ff;
    reg         light_enable_out_ff;
    reg         hl_ff;
    reg         hret_out_ff;
    reg         vret_out_ff;

    wire        bus_req = read | write;
    wire        wr_go   = write & served_ff;
    wire        rd_go   = read & served_ff;

    wire        disp_en = ctrl_ff[`CTRL_EN_BIT];
    wire        irq_en  = ctrl_ff[`CTRL_IRQEN_BIT];
    wire        spaced  = ctrl_ff[`CTRL_SPACED_BIT];
    wire        lmode   = ctrl_ff[`CTRL_LMODE_BIT];

    wire [6:0]  chars_raw = fmt_a_ff[`CHARS_LSB +: 7];
    // Out-of-range widths are clamped so the buffer index never leaves its half
    wire [6:0]  chars_m1  = (chars_raw > `MAX_COL) ? `MAX_COL : chars_raw;
    wire [5:0]  rows_m1   = fmt_a_ff[`ROWS_LSB +: 6];
    wire [1:0]  vret_m1   = fmt_a_ff[`VRET_LSB +: 2];
    wire [3:0]  lines_m1  = fmt_a_ff[`LINES_LSB +: 4];
    wire [3:0]  ul_line   = fmt_a_ff[`UL_LSB +: 4];
    wire [4:0]  hret_m1   = fmt_b_ff[`HRET_LSB +: 5];
    wire [2:0]  burst_m1  = fmt_b_ff[`BURST_LSB +: 3];
    wire [5:0]  space_cfg = fmt_b_ff[`SPACE_LSB +: 6];

    // Raster events
    wire        line_end  = ~hret_ff & (col_ff >= chars_m1);
    wire        hret_end  = hret_ff & (hcnt_ff >= hret_m1);
    wire        row_end   = line_end & (line_ff >= lines_m1);
    wire        row_start = ~hret_ff & (col_ff == 7'h00) & (line_ff == 4'h0);
    wire        row_disp  = ~spaced | ~row_ff[0];
    wire        next_disp = ~spaced | row_ff[0];

    // R1 R15: last vertical retrace row fetches row 0
    wire        launch_v  = row_start & vret_ff & (vcnt_ff >= vret_m1);
    // R4 R17: preceding row fetches the next shown row
    wire        launch_r  = row_start & ~vret_ff & (row_ff < rows_m1) & next_disp;
    wire        launch    = disp_en & (launch_v | launch_r);
    // R2: swap roles as each shown row begins
    wire        swap      = row_start & ~vret_ff & row_disp;
    // R18: fill started but incomplete at swap
    wire        underrun_set = disp_en & swap & fill_req_ff & ~fill_full_ff;
    // R19: last display row begins
    wire        irq_set   = irq_en & row_start & ~vret_ff & (row_ff == rows_m1) & row_disp;

    wire        take      = dma_state_ff[2] & dma_ack;
    wire        rst_cmd   = wr_go & (address == `CTRL_OFS) & writedata[`CTRL_RST_BIT];
    wire        st_read   = rd_go & (address == `STATUS_OFS);

    wire [7:0]  wr_addr   = disp_sel_ff ? {1'b0, fill_ptr_ff} : (`ROW_LEN + {1'b0, fill_ptr_ff});
    wire [7:0]  rd_addr   = disp_sel_ff ? (`ROW_LEN + {1'b0, col_ff}) : {1'b0, col_ff};
    wire [7:0]  cur_char  = row_mem[rd_addr];

    // One wait state per access; readdata is loaded during it
    assign waitrequest     = bus_req & ~served_ff;
    assign readdata        = readdata_ff;
    assign dma_request_out = dma_state_ff[2];
    assign irq_out         = irq_ff;
    assign character_code_out     = code_ff;
    assign line_count_out         = lc_ff;
    assign video_suppress_out     = vsp_ff;
    assign light_enable_out       = light_enable_out_ff;
    assign highlight_out          = hl_ff;
    assign horizontal_retrace_out = hret_out_ff;
    assign vertical_retrace_out   = vret_out_ff;

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            served_ff   <= 1'b0;
            readdata_ff <= 32'h0000_0000;
            ctrl_ff     <= `CTRL_RST_VAL;
            fmt_a_ff    <= `FMT_A_RST_VAL;
            fmt_b_ff    <= `FMT_B_RST_VAL;
        end else begin
            served_ff <= bus_req & ~served_ff;
            if (read & ~served_ff) begin
                case (address)
                    `CTRL_OFS:   readdata_ff <= {28'h000_0000, ctrl_ff};
                    `FMT_A_OFS:  readdata_ff <= {4'h0, fmt_a_ff};
                    `FMT_B_OFS:  readdata_ff <= {10'h000, fmt_b_ff};
                    `STATUS_OFS: readdata_ff <= {28'h000_0000, fill_full_ff, vret_ff,
                                                 underrun_ff, irq_ff};
                    default:     readdata_ff <= 32'h0000_0000;
                endcase
            end
            if (wr_go) begin
                case (address)
                    `CTRL_OFS: begin
                        // R20: reset command disables display and interrupts
                        if (writedata[`CTRL_RST_BIT]) begin
                            ctrl_ff <= {writedata[3:2], 2'b00};
                        end else begin
                            ctrl_ff <= writedata[3:0];
                        end
                    end
                    `FMT_A_OFS: fmt_a_ff <= writedata[27:0];
                    `FMT_B_OFS: fmt_b_ff <= writedata[21:0];
                    default: ;
                endcase
            end
        end
    end

    // Sticky status; a set in the clearing cycle wins
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irq_ff      <= 1'b0;
            underrun_ff <= 1'b0;
        end else begin
            // R19 R20: status read or reset command clears
            if (irq_set) begin
                irq_ff <= 1'b1;
            end else if (st_read | rst_cmd) begin
                irq_ff <= 1'b0;
            end
            // R18: underrun flag held until status read
            if (underrun_set) begin
                underrun_ff <= 1'b1;
            end else if (st_read) begin
                underrun_ff <= 1'b0;
            end
        end
    end

    // R23: raster counters run every character clock, even when disabled
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            col_ff   <= 7'h00;
            hret_ff  <= 1'b0;
            hcnt_ff  <= 5'h00;
            line_ff  <= 4'h0;
            row_ff   <= 6'h00;
            vret_ff  <= 1'b0;
            vcnt_ff  <= 2'h0;
            frame_ff <= 5'h00;
        end else begin
            if (line_end) begin
                // R10 R5: line advances as horizontal retrace begins
                hret_ff <= 1'b1;
                hcnt_ff <= 5'h00;
                if (row_end) begin
                    // R6 R11: wrap after programmed lines, next row
                    line_ff <= 4'h0;
                    if (!vret_ff) begin
                        if (row_ff >= rows_m1) begin
                            // R3 R12: frame done, vertical retrace rows follow
                            vret_ff <= 1'b1;
                            vcnt_ff <= 2'h0;
                        end else begin
                            row_ff <= row_ff + 6'h01;
                        end
                    end else if (vcnt_ff >= vret_m1) begin
                        vret_ff  <= 1'b0;
                        row_ff   <= 6'h00;
                        frame_ff <= frame_ff + 5'h01;
                    end else begin
                        vcnt_ff <= vcnt_ff + 2'h1;
                    end
                end else begin
                    line_ff <= line_ff + 4'h1;
                end
            end else if (hret_end) begin
                hret_ff <= 1'b0;
                col_ff  <= 7'h00;
            end else if (hret_ff) begin
                // R10: retrace length programmable
                hcnt_ff <= hcnt_ff + 5'h01;
            end else begin
                col_ff <= col_ff + 7'h01;
            end
        end
    end

    // Row buffer storage; no reset so it maps onto memory
    always @(posedge mclk) begin
        if (take) begin
            row_mem[wr_addr] <= dma_data;
        end
    end

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            disp_sel_ff  <= 1'b0;
            row_ok_ff    <= 1'b0;
            fill_req_ff  <= 1'b0;
            fill_full_ff <= 1'b0;
            fill_ptr_ff  <= 7'h00;
            burst_ff     <= 3'h0;
            space_ff     <= 6'h00;
            dma_state_ff <= DMA_IDLE;
        end else if (!disp_en) begin
            // Requests stop while display is disabled
            row_ok_ff    <= 1'b0;
            fill_req_ff  <= 1'b0;
            fill_full_ff <= 1'b0;
            burst_ff     <= 3'h0;
            dma_state_ff <= DMA_IDLE;
        end else begin
            if (swap) begin
                // R2: filled buffer becomes the display buffer
                disp_sel_ff  <= ~disp_sel_ff;
                row_ok_ff    <= fill_req_ff & fill_full_ff;
                fill_req_ff  <= 1'b0;
                fill_full_ff <= 1'b0;
                burst_ff     <= 3'h0;
                dma_state_ff <= DMA_IDLE;
            end
            if (launch) begin
                // R17: first request delayed by the burst space
                fill_req_ff  <= 1'b1;
                fill_full_ff <= 1'b0;
                fill_ptr_ff  <= 7'h00;
                burst_ff     <= 3'h0;
                space_ff     <= space_cfg;
                dma_state_ff <= (space_cfg == 6'h00) ? DMA_BURST : DMA_SPACE;
            end else if (!swap) begin
                case (dma_state_ff)
                    DMA_IDLE: ;
                    DMA_SPACE: begin
                        // R14: gap between bursts
                        if (space_ff <= 6'h01) begin
                            dma_state_ff <= DMA_BURST;
                        end else begin
                            space_ff <= space_ff - 6'h01;
                        end
                    end
                    DMA_BURST: begin
                        if (dma_ack) begin
                            if (fill_ptr_ff >= chars_m1) begin
                                // R16: full mid-burst ends requests for this row
                                fill_full_ff <= 1'b1;
                                burst_ff     <= 3'h0;
                                dma_state_ff <= DMA_IDLE;
                            end else begin
                                fill_ptr_ff <= fill_ptr_ff + 7'h01;
                                // R14: burst length then spacing
                                if (burst_ff >= burst_m1) begin
                                    burst_ff <= 3'h0;
                                    space_ff <= space_cfg;
                                    if (space_cfg != 6'h00) begin
                                        dma_state_ff <= DMA_SPACE;
                                    end
                                end else begin
                                    burst_ff <= burst_ff + 3'h1;
                                end
                            end
                        end
                    end
                    default: dma_state_ff <= DMA_IDLE;
                endcase
            end
        end
    end

    // Video outputs, one register stage after the counters
    reg        nxt_vsp;
    reg        nxt_light_enable_out;
    reg        nxt_hl;
    reg  [6:0] nxt_code;
    reg  [3:0] nxt_lc;
    reg        retrace;
    reg        shown;
    reg        is_attr;
    reg        top_bot;

    always @* begin
        retrace = hret_ff | vret_ff;
        // R4: blanked rows and rows that never filled are suppressed
        shown   = disp_en & row_disp & row_ok_ff & ~retrace;
        // R21: MSB marks an attribute rather than a display code
        is_attr = cur_char[7];
        // R9: underline line above 7 blanks first and last lines
        top_bot = ul_line[3] & ((line_ff == 4'h0) | (line_ff == lines_m1));
        // R13: suppress over every retrace interval
        nxt_vsp = retrace | ~shown | top_bot;
        // R22: blink at refresh rate divided by 32
        if (is_attr & cur_char[1] & frame_ff[`BLINK_BIT]) begin
            nxt_vsp = 1'b1;
        end
        // R21: seven low bits drive the character generator
        nxt_code = (shown & ~is_attr) ? cur_char[6:0] : 7'h00;
        // R22: highlight attribute
        nxt_hl   = shown & is_attr & cur_char[0];
        // R8 R9: underline by line number; beyond the last line never matches
        nxt_light_enable_out = shown & is_attr & (cur_char[5:2] == `ATTR_HLINE) & (line_ff == ul_line);
        // R7: mode 1 shows the previous line, line 0 shows the last count
        if (lmode) begin
            nxt_lc = (line_ff == 4'h0) ? lines_m1 : (line_ff - 4'h1);
        end else begin
            nxt_lc = line_ff;
        end
    end

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            code_ff     <= 7'h00;
            lc_ff       <= 4'h0;
            vsp_ff      <= 1'b1;
            light_enable_out_ff     <= 1'b0;
            hl_ff       <= 1'b0;
            hret_out_ff <= 1'b0;
            vret_out_ff <= 1'b0;
        end else begin
            code_ff     <= nxt_code;
            // R5 R6: line count held for the whole sweep
            lc_ff       <= nxt_lc;
            vsp_ff      <= nxt_vsp;
            light_enable_out_ff     <= nxt_light_enable_out;
            hl_ff       <= nxt_hl;
            // R23: retrace outputs change only on clock edges
            hret_out_ff <= hret_ff;
            vret_out_ff <= vret_ff;
        end
    end

endmodule

//--- dv/crt_raster_row_buffer_monitor.sv
`timescale 1ns/1ps
module crt_raster_row_buffer_monitor (
    input wire        mclk,
    input wire        reset_n,
    input wire [3:0]  address,
    input wire        read,
    input wire        write,
    input wire [31:0] writedata,
    input wire        waitrequest,
    input wire        dma_request_out,
    input wire        dma_ack,
    input wire        irq_out,
    input wire [3:0]  line_count_out,
    input wire        video_suppress_out,
    input wire        horizontal_retrace_out,
    input wire        vertical_retrace_out
);
    reg [2:0] burst_m1_ff;
    reg [5:0] space_ff;
    reg       irq_en_ff;
    reg [3:0] take_cnt_ff;
    wire      wr_done = write && !waitrequest;

    // Shadow of software settings
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            burst_m1_ff <= 3'h3;
            space_ff    <= 6'h07;
            irq_en_ff   <= 1'b0;
            take_cnt_ff <= 4'h0;
        end else begin
            if (wr_done && address == 4'h8) begin
                burst_m1_ff <= writedata[10:8];
                space_ff    <= writedata[21:16];
            end
            if (wr_done && address == 4'h0) begin
                irq_en_ff <= writedata[1] && !writedata[4];
            end
            if (!dma_request_out) begin
                take_cnt_ff <= 4'h0;
            end else if (dma_ack) begin
                take_cnt_ff <= take_cnt_ff + 4'h1;
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    chk_wait_first: assert property ($rose(read || write) |-> waitrequest)
        else $error("no wait state");
    chk_wait_once: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("extra wait state");
    chk_hret_blank: assert property (horizontal_retrace_out |-> video_suppress_out)
        else $error("no blank in hret");
    chk_vret_blank: assert property (vertical_retrace_out |-> video_suppress_out)
        else $error("no blank in vret");
    chk_line_steady: assert property (!horizontal_retrace_out &&
        $past(!horizontal_retrace_out) && !$past(write) && !$past(write, 2)
        |-> $stable(line_count_out)) else $error("line count moved");
    chk_hret_min: assert property ($rose(horizontal_retrace_out)
        |=> horizontal_retrace_out) else $error("hret too short");
    chk_irq_clear: assert property (read && !waitrequest && address == 4'hC
        |=> !irq_out) else $error("irq stayed");
    chk_irq_enable: assert property ($rose(irq_out) |-> irq_en_ff)
        else $error("irq while disabled");
    chk_burst_end: assert property (dma_request_out && dma_ack && space_ff != 6'h00
        && take_cnt_ff == {1'b0, burst_m1_ff} |=> !dma_request_out)
        else $error("burst too long");
    chk_burst_gap: assert property ($fell(dma_request_out) && space_ff > 6'h02
        |=> !dma_request_out) else $error("burst gap too short");
endmodule

bind crt_raster_row_buffer crt_raster_row_buffer_monitor u_mon (
    .mclk(mclk), .reset_n(reset_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .waitrequest(waitrequest),
    .dma_request_out(dma_request_out), .dma_ack(dma_ack),
    .irq_out(irq_out), .line_count_out(line_count_out),
    .video_suppress_out(video_suppress_out),
    .horizontal_retrace_out(horizontal_retrace_out),
    .vertical_retrace_out(vertical_retrace_out));

//--- dv/dma_source_model.sv
`timescale 1ns/1ps
module dma_source_model (
    input wire       mclk,
    input wire       reset_n,
    input wire       dma_request_out,
    input wire [1:0] pace,
    output reg       dma_ack,
    output reg [7:0] dma_data
);
    reg [6:0] seq_ff;
    reg       nxt_ack;

    always @* begin
        // Pace 0 prompt, 1 every other cycle, 2 never answers
        nxt_ack = dma_request_out && (pace == 2'h0 || (pace == 2'h1 && !dma_ack));
    end

    // serve fill requests with display codes, except at pace 2, which never answers
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            dma_ack  <= 1'b0;
            dma_data <= 8'h55;
            seq_ff   <= 7'h00;
        end else begin
            if (dma_ack && dma_request_out) begin
                seq_ff <= seq_ff + 7'h01;
            end
            dma_ack <= nxt_ack;
            // Idle bus toggles each cycle between the last byte and its inverse
            dma_data <= nxt_ack ? {1'b0, seq_ff} : ~dma_data;
        end
    end
endmodule

//--- dv/crt_raster_row_buffer_tb.sv
`timescale 1ns/1ps
module crt_raster_row_buffer_tb;
    reg         mclk;
    reg         reset_n;
    reg  [3:0]  address;
    reg         read;
    reg         write;
    reg  [31:0] writedata;
    reg  [1:0]  pace;
    wire [31:0] readdata;
    wire        waitrequest, dma_request_out, dma_ack, irq_out, video_suppress_out;
    wire        light_enable_out, highlight_out, horizontal_retrace_out, vertical_retrace_out;
    wire [7:0]  dma_data;
    wire [6:0]  character_code_out;
    wire [3:0]  line_count_out;
    integer     err_count, total_checks, sc_takes, sc_run, sc_max, sc_period, len, i;
    reg  [31:0] rd;
    reg  [68:0] rows [0:6];

    crt_raster_row_buffer uut (.mclk(mclk), .reset_n(reset_n), .address(address),
        .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .dma_request_out(dma_request_out), .dma_ack(dma_ack),
        .dma_data(dma_data), .irq_out(irq_out), .character_code_out(character_code_out),
        .line_count_out(line_count_out), .video_suppress_out(video_suppress_out),
        .light_enable_out(light_enable_out), .highlight_out(highlight_out),
        .horizontal_retrace_out(horizontal_retrace_out),
        .vertical_retrace_out(vertical_retrace_out));
    dma_source_model partner (.mclk(mclk), .reset_n(reset_n),
        .dma_request_out(dma_request_out), .pace(pace), .dma_ack(dma_ack), .dma_data(dma_data));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task close_out;
        $display("checks=%0d errors=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task chk(input [31:0] got, input [31:0] exp, input string what);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Holds request until waitrequest low at a rising edge
    task bus(input logic wr, input [3:0] a, input [31:0] wd, output [31:0] d);
        integer n;
        @(posedge mclk);
        address <= a;
        writedata <= wd;
        read <= !wr;
        write <= wr;
        n = 0;
        @(posedge mclk);
        while (waitrequest !== 1'b0 && n < 50) begin
            n = n + 1;
            @(posedge mclk);
        end
        if (n >= 50) chk(1, 0, "bus hang");
        d = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    function logic pick(input integer sel);
        pick = (sel == 0) ? horizontal_retrace_out : (sel == 1) ? vertical_retrace_out : irq_out;
    endfunction

    task wait_lvl(input integer sel, input logic lvl);
        integer n;
        n = 0;
        @(negedge mclk);
        while (pick(sel) !== lvl && n < 2000) begin
            n = n + 1;
            @(negedge mclk);
        end
        if (n >= 2000) chk(sel, 99, "level timeout");
    endtask

    task high_len(input integer sel);
        wait_lvl(sel, 1'b0);
        wait_lvl(sel, 1'b1);
        len = 0;
        while (pick(sel) === 1'b1 && len < 2000) begin
            len = len + 1;
            @(negedge mclk);
        end
    endtask

    task scan_step;
        if (dma_request_out !== 1'b1) sc_run = 0;
        if (dma_request_out === 1'b1 && dma_ack === 1'b1) begin
            sc_takes = sc_takes + 1;
            sc_run = sc_run + 1;
        end
        if (sc_run > sc_max) sc_max = sc_run;
        sc_period = sc_period + 1;
        @(negedge mclk);
    endtask

    // One frame, from a vertical retrace start to the next
    task frame_scan;
        wait_lvl(1, 1'b0);
        wait_lvl(1, 1'b1);
        sc_takes = 0;
        sc_run = 0;
        sc_max = 0;
        sc_period = 0;
        while (vertical_retrace_out === 1'b1 && sc_period < 5000) scan_step();
        while (vertical_retrace_out !== 1'b1 && sc_period < 5000) scan_step();
    endtask

    initial begin
        #(20 * 40000);
        $display("[FAIL] %0t watchdog expired", $time);
        err_count = err_count + 1;
        close_out();
    end

    initial begin
        err_count = 0;
        total_checks = 0;
        reset_n = 1'b0;
        address = 4'h0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        pace = 2'h0;
        // 8 chars, 4 rows, 1 retrace row, 4 lines, hret 4, bursts of 3 spaced 4
        rows[0] = {1'b0, 4'h0, 32'h0, 32'h0};
        rows[1] = {1'b0, 4'h4, 32'h0, 32'h0999184F};
        rows[2] = {1'b0, 4'h8, 32'h0, 32'h0007030F};
        rows[3] = {1'b0, 4'h2, 32'h0, 32'h0};
        rows[4] = {1'b1, 4'h4, 32'h02300307, 32'h02300307};
        rows[5] = {1'b1, 4'h8, 32'h00040203, 32'h00040203};
        rows[6] = {1'b1, 4'h2, 32'hFFFFFFFF, 32'h0};
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        bus(1'b1, 4'h0, 32'h10, rd);
        for (i = 0; i <= 6; i = i + 1) begin
            if (rows[i][68]) bus(1'b1, rows[i][67:64], rows[i][63:32], rd);
            bus(1'b0, rows[i][67:64], 32'h0, rd);
            chk(rd, rows[i][31:0], "register readback");
        end
        pace <= 2'h1;
        bus(1'b1, 4'h0, 32'h3, rd);
        frame_scan();
        frame_scan();
        chk(sc_takes, 32, "frame fetches");
        chk(sc_max, 3, "takes per burst");
        chk(sc_period, 240, "frame period");
        high_len(0);
        chk(len, 4, "hret length");
        high_len(1);
        chk(len, 48, "vret length");
        wait_lvl(1, 1'b0);
        wait_lvl(0, 1'b0);
        chk(line_count_out, 4'h0, "mode 0 count");
        wait_lvl(2, 1'b1);
        bus(1'b0, 4'hC, 32'h0, rd);
        chk(rd[0], 1'b1, "interrupt status");
        @(negedge mclk);
        chk(irq_out, 1'b0, "irq after read");
        bus(1'b1, 4'h0, 32'hB, rd);
        wait_lvl(1, 1'b1);
        wait_lvl(1, 1'b0);
        wait_lvl(0, 1'b0);
        chk(line_count_out, 4'h3, "mode 1 count");
        bus(1'b1, 4'h0, 32'h7, rd);
        frame_scan();
        frame_scan();
        chk(sc_takes, 16, "spaced fetches");
        pace <= 2'h2;
        bus(1'b1, 4'h0, 32'h1, rd);
        frame_scan();
        bus(1'b0, 4'hC, 32'h0, rd);
        chk(rd[1], 1'b1, "underrun status");
        pace <= 2'h0;
        @(posedge mclk);
        reset_n <= 1'b0;
        @(negedge mclk);
        chk({video_suppress_out, dma_request_out, irq_out}, 3'b100, "outputs in reset");
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        bus(1'b0, 4'h4, 32'h0, rd);
        chk(rd, 32'h0999184F, "format after reset");
        close_out();
    end
endmodule
